// ---- iorsm_regs.sv ----
// iorsm_regs: decoder and register bank of the 256-byte internal register window.
// assumes bus strobes are one-cycle pulses synchronous to clk; window select from user decode.
`timescale 1ns/1ps
// Overview of operation
// - decode 256-byte register window, offsets relative to window base
// - input registers of ports a to d return current pin levels
// - ports a and b control registers choose io or latched address per pin
// - output registers hold written value and drive io-mode pins used as outputs
// - direction registers set each io-mode pin as input or output
// - drive registers choose push-pull/open-drain or high slew per pin
// - enable status registers return current driver output enables
// - offset 20h reads first cell group outputs, write loads its flip-flops
// - offset 21h reads second cell group outputs, write loads its flip-flops
// - first mask register blocks writes into first cell group bits
// - second mask register blocks writes into second cell group bits
// - read-only register reports primary flash sector protection
// - read-only register reports security and secondary sector protection
// - space map register places each memory area in program/data space
// - latched address bits a7-a0, pin for pin, on ports a,b (mux) or b only
// - eight primary, four secondary sector selects and sram select from decode
module iorsm_regs #(
	parameter int PORT_W = 8,
	parameter int PORTD_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic registerWindowSelect,
	input wire logic [iorsm_pkg::ADDR_W-1:0] busAddr,
	input wire logic [iorsm_pkg::DATA_W-1:0] busWrData,
	input wire logic busWrStrobe,
	input wire logic busRdStrobe,
	output logic [iorsm_pkg::DATA_W-1:0] busRdData,
	input wire iorsm_pkg::iorsm_bus_t busType,
	input wire logic [7:0] latchedAddr,
	input wire logic [PORT_W-1:0] portAPinIn,
	input wire logic [PORT_W-1:0] portBPinIn,
	input wire logic [PORT_W-1:0] portCPinIn,
	input wire logic [PORTD_W-1:0] portDPinIn,
	output logic [PORT_W-1:0] portAPinOut,
	output logic [PORT_W-1:0] portAPinOe,
	output logic [PORT_W-1:0] portBPinOut,
	output logic [PORT_W-1:0] portBPinOe,
	output logic [PORT_W-1:0] portCPinOut,
	output logic [PORT_W-1:0] portCPinOe,
	output logic [PORTD_W-1:0] portDPinOut,
	output logic [PORTD_W-1:0] portDPinOe,
	output logic [PORT_W-1:0] portADriveType,
	output logic [PORT_W-1:0] portBDriveType,
	output logic [PORT_W-1:0] portCDriveType,
	output logic [PORTD_W-1:0] portDDriveType,
	input wire logic [PORT_W-1:0] portAInputCells,
	input wire logic [PORT_W-1:0] portBInputCells,
	input wire logic [PORT_W-1:0] portCInputCells,
	input wire logic [7:0] firstCellOutputs,
	input wire logic [7:0] secondCellOutputs,
	output logic [7:0] firstCellLoadData,
	output logic [7:0] firstCellLoadEnable,
	output logic [7:0] secondCellLoadData,
	output logic [7:0] secondCellLoadEnable,
	input wire logic [iorsm_pkg::PRI_SECTORS-1:0] primarySectorLocked,
	input wire logic [7:0] securityAndSecondaryLocked,
	output logic [7:0] powerControl0,
	output logic [7:0] powerControl2,
	output logic [7:0] testPortEnable,
	output logic [7:0] addressPage,
	output logic [7:0] memorySpaceMap,
	input wire logic [iorsm_pkg::PRI_SECTORS-1:0] decodePrimarySel,
	input wire logic [iorsm_pkg::SEC_SECTORS-1:0] decodeSecondarySel,
	input wire logic decodeSramSel,
	output logic [iorsm_pkg::PRI_SECTORS-1:0] primarySectorSelects,
	output logic [iorsm_pkg::SEC_SECTORS-1:0] secondarySectorSelects,
	output logic sramSelect
);
	import iorsm_pkg::*;

	logic [PORT_W-1:0] aCtl_q, bCtl_q;
	logic [PORT_W-1:0] aOut_q, bOut_q, cOut_q;
	logic [PORTD_W-1:0] dOut_q;
	logic [PORT_W-1:0] aDir_q, bDir_q, cDir_q;
	logic [PORTD_W-1:0] dDir_q;
	logic [PORT_W-1:0] aDrv_q, bDrv_q, cDrv_q;
	logic [PORTD_W-1:0] dDrv_q;
	logic [7:0] mskAb_q, mskBc_q;
	logic [7:0] pwr0_q, pwr2_q, testEn_q, page_q, spaceMap_q;
	logic [7:0] rdData_d;
	logic wrEn;
	logic [7:0] addrNibA, addrNibB;

	function automatic logic [7:0] zx(input logic [PORT_W-1:0] v);
		zx = 8'(v);
	endfunction

	assign wrEn = registerWindowSelect && busWrStrobe;

	function automatic logic hit(input logic [7:0] off);
		hit = wrEn && (busAddr == off);
	endfunction

	always_ff @(posedge clk) begin
		if (rst) begin
			aCtl_q <= '0;
			bCtl_q <= '0;
			aDir_q <= '0;
			bDir_q <= '0;
			cDir_q <= '0;
			dDir_q <= '0;
			aDrv_q <= '0;
			bDrv_q <= '0;
			cDrv_q <= '0;
			dDrv_q <= '0;
		end else begin
			if (hit(OFF_A_CTL)) aCtl_q <= busWrData[PORT_W-1:0];
			if (hit(OFF_B_CTL)) bCtl_q <= busWrData[PORT_W-1:0];
			if (hit(OFF_A_DIR)) aDir_q <= busWrData[PORT_W-1:0];
			if (hit(OFF_B_DIR)) bDir_q <= busWrData[PORT_W-1:0];
			if (hit(OFF_C_DIR)) cDir_q <= busWrData[PORT_W-1:0];
			if (hit(OFF_D_DIR)) dDir_q <= busWrData[PORTD_W-1:0];
			if (hit(OFF_A_DRV)) aDrv_q <= busWrData[PORT_W-1:0];
			if (hit(OFF_B_DRV)) bDrv_q <= busWrData[PORT_W-1:0];
			if (hit(OFF_C_DRV)) cDrv_q <= busWrData[PORT_W-1:0];
			if (hit(OFF_D_DRV)) dDrv_q <= busWrData[PORTD_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			aOut_q <= '0;
			bOut_q <= '0;
			cOut_q <= '0;
			dOut_q <= '0;
		end else begin
			if (hit(OFF_A_OUT)) aOut_q <= busWrData[PORT_W-1:0];
			if (hit(OFF_B_OUT)) bOut_q <= busWrData[PORT_W-1:0];
			if (hit(OFF_C_OUT)) cOut_q <= busWrData[PORT_W-1:0];
			if (hit(OFF_D_OUT)) dOut_q <= busWrData[PORTD_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mskAb_q <= RST_REG;
			mskBc_q <= RST_REG;
		end else begin
			if (hit(OFF_MSK_AB)) mskAb_q <= busWrData;
			if (hit(OFF_MSK_BC)) mskBc_q <= busWrData;
		end
	end

	// power, test, page and space map registers
	always_ff @(posedge clk) begin
		if (rst) begin
			pwr0_q <= RST_REG;
			pwr2_q <= RST_REG;
			testEn_q <= RST_REG;
			page_q <= RST_REG;
			spaceMap_q <= RST_REG;
		end else begin
			if (hit(OFF_PWR0)) pwr0_q <= busWrData;
			if (hit(OFF_PWR2)) pwr2_q <= busWrData;
			if (hit(OFF_TEST_EN)) testEn_q <= busWrData;
			if (hit(OFF_PAGE)) page_q <= busWrData;
			if (hit(OFF_SPACE_MAP)) spaceMap_q <= busWrData;
		end
	end

	assign powerControl0 = pwr0_q;
	assign powerControl2 = pwr2_q;
	assign testPortEnable = testEn_q;
	assign addressPage = page_q;
	assign memorySpaceMap = spaceMap_q;
	assign portADriveType = aDrv_q;
	assign portBDriveType = bDrv_q;
	assign portCDriveType = cDrv_q;
	assign portDDriveType = dDrv_q;

	// first and second group loads, masked bits untouched
	assign firstCellLoadData = busWrData;
	assign firstCellLoadEnable = hit(OFF_OMC_AB) ? ~mskAb_q : 8'h00;
	assign secondCellLoadData = busWrData;
	assign secondCellLoadEnable = hit(OFF_OMC_BC) ? ~mskBc_q : 8'h00;

	// latched address bytes per bus type
	assign addrNibA = (busType == IORSM_BUS_MUX) ? latchedAddr : 8'h00;
	assign addrNibB = latchedAddr;

	always_comb begin
		for (int i = 0; i < PORT_W; i++) begin
			portAPinOut[i] = aCtl_q[i] ? addrNibA[i % 8] : aOut_q[i];
			portAPinOe[i] = aCtl_q[i] ? (busType == IORSM_BUS_MUX) : aDir_q[i];
			portBPinOut[i] = bCtl_q[i] ? addrNibB[i % 8] : bOut_q[i];
			portBPinOe[i] = bCtl_q[i] ? 1'b1 : bDir_q[i];
		end
	end
	assign portCPinOut = cOut_q;
	assign portCPinOe = cDir_q;
	assign portDPinOut = dOut_q;
	assign portDPinOe = dDir_q;

	// memory selects pass from the decode array
	assign primarySectorSelects = decodePrimarySel;
	assign secondarySectorSelects = decodeSecondarySel;
	assign sramSelect = decodeSramSel;

	always_comb begin
		rdData_d = 8'h00;
		unique case (busAddr)
			OFF_A_IN: rdData_d = zx(portAPinIn);
			OFF_B_IN: rdData_d = zx(portBPinIn);
			OFF_C_IN: rdData_d = zx(portCPinIn);
			OFF_D_IN: rdData_d = 8'(portDPinIn);
			OFF_A_CTL: rdData_d = zx(aCtl_q);
			OFF_B_CTL: rdData_d = zx(bCtl_q);
			OFF_A_OUT: rdData_d = zx(aOut_q);
			OFF_B_OUT: rdData_d = zx(bOut_q);
			OFF_C_OUT: rdData_d = zx(cOut_q);
			OFF_D_OUT: rdData_d = 8'(dOut_q);
			OFF_A_DIR: rdData_d = zx(aDir_q);
			OFF_B_DIR: rdData_d = zx(bDir_q);
			OFF_C_DIR: rdData_d = zx(cDir_q);
			OFF_D_DIR: rdData_d = 8'(dDir_q);
			OFF_A_DRV: rdData_d = zx(aDrv_q);
			OFF_B_DRV: rdData_d = zx(bDrv_q);
			OFF_C_DRV: rdData_d = zx(cDrv_q);
			OFF_D_DRV: rdData_d = 8'(dDrv_q);
			OFF_A_IMC: rdData_d = zx(portAInputCells);
			OFF_B_IMC: rdData_d = zx(portBInputCells);
			OFF_C_IMC: rdData_d = zx(portCInputCells);
			OFF_A_OEN: rdData_d = zx(portAPinOe);
			OFF_B_OEN: rdData_d = zx(portBPinOe);
			OFF_C_OEN: rdData_d = zx(portCPinOe);
			OFF_D_OEN: rdData_d = 8'(portDPinOe);
			OFF_OMC_AB: rdData_d = firstCellOutputs;
			OFF_OMC_BC: rdData_d = secondCellOutputs;
			OFF_MSK_AB: rdData_d = mskAb_q;
			OFF_MSK_BC: rdData_d = mskBc_q;
			OFF_PWR0: rdData_d = pwr0_q;
			OFF_PWR2: rdData_d = pwr2_q;
			OFF_PRI_LOCK: rdData_d = 8'(primarySectorLocked);
			OFF_SEC_LOCK: rdData_d = securityAndSecondaryLocked;
			OFF_TEST_EN: rdData_d = testEn_q;
			OFF_PAGE: rdData_d = page_q;
			OFF_SPACE_MAP: rdData_d = spaceMap_q;
			default: rdData_d = 8'h00;
		endcase
	end

	// read data registered on the read strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			busRdData <= 8'h00;
		end else if (registerWindowSelect && busRdStrobe) begin
			busRdData <= rdData_d;
		end
	end

	AST_PIN_READ_A: assert property (@(posedge clk) disable iff (rst)
		registerWindowSelect && busRdStrobe && busAddr == OFF_A_IN
		|=> busRdData == zx($past(portAPinIn)))
		else $error("port a input read mismatch");
	AST_PIN_READ_D: assert property (@(posedge clk) disable iff (rst)
		registerWindowSelect && busRdStrobe && busAddr == OFF_D_IN
		|=> busRdData == 8'($past(portDPinIn)))
		else $error("port d input read mismatch");
	AST_CTL_MUX_B: assert property (@(posedge clk) disable iff (rst)
		bCtl_q[0] |-> portBPinOut[0] == latchedAddr[0] && portBPinOe[0])
		else $error("port b address output wrong");
	AST_CTL_MUX_A: assert property (@(posedge clk) disable iff (rst)
		aCtl_q[3] && busType == IORSM_BUS_MUX
		|-> portAPinOut[3] == latchedAddr[3] && portAPinOe[3])
		else $error("port a address output wrong");
	AST_NONMUX_A: assert property (@(posedge clk) disable iff (rst)
		aCtl_q[0] && busType == IORSM_BUS_NONMUX |-> !portAPinOe[0])
		else $error("port a driven on non-multiplexed bus");
	AST_OUT_WRITE_C: assert property (@(posedge clk) disable iff (rst)
		hit(OFF_C_OUT) |=> portCPinOut == $past(busWrData[PORT_W-1:0]))
		else $error("port c output not loaded");
	AST_OUT_WRITE_A: assert property (@(posedge clk) disable iff (rst)
		hit(OFF_A_OUT) && !aCtl_q[0] |=> portAPinOut[0] == $past(busWrData[0]))
		else $error("port a output not loaded");
	AST_DIR_WRITE_D: assert property (@(posedge clk) disable iff (rst)
		hit(OFF_D_DIR) |=> portDPinOe == $past(busWrData[PORTD_W-1:0]))
		else $error("port d direction not loaded");
	AST_DIR_WRITE_B: assert property (@(posedge clk) disable iff (rst)
		hit(OFF_B_DIR) && !bCtl_q[7] |=> portBPinOe[7] == $past(busWrData[7]))
		else $error("port b direction not loaded");
	AST_DRV_HOLD: assert property (@(posedge clk) disable iff (rst)
		!hit(OFF_A_DRV) |=> $stable(portADriveType))
		else $error("drive type changed without write");
	AST_DRV_WRITE_C: assert property (@(posedge clk) disable iff (rst)
		hit(OFF_C_DRV) |=> portCDriveType == $past(busWrData[PORT_W-1:0]))
		else $error("port c drive type not loaded");
	AST_OEN_READ_C: assert property (@(posedge clk) disable iff (rst)
		registerWindowSelect && busRdStrobe && busAddr == OFF_C_OEN
		|=> busRdData == zx($past(portCPinOe)))
		else $error("port c enable status read mismatch");
	AST_CELL_READ_AB: assert property (@(posedge clk) disable iff (rst)
		registerWindowSelect && busRdStrobe && busAddr == OFF_OMC_AB
		|=> busRdData == $past(firstCellOutputs))
		else $error("first cell group read mismatch");
	AST_CELL_READ_BC: assert property (@(posedge clk) disable iff (rst)
		registerWindowSelect && busRdStrobe && busAddr == OFF_OMC_BC
		|=> busRdData == $past(secondCellOutputs))
		else $error("second cell group read mismatch");
	AST_MASK_AB: assert property (@(posedge clk) disable iff (rst)
		hit(OFF_MSK_AB) |=> mskAb_q == $past(busWrData))
		else $error("first group mask not stored");
	AST_MASK_BC: assert property (@(posedge clk) disable iff (rst)
		hit(OFF_OMC_BC) |-> secondCellLoadEnable == ~mskBc_q)
		else $error("second group load enable wrong");
	AST_PRI_LOCK: assert property (@(posedge clk) disable iff (rst)
		registerWindowSelect && busRdStrobe && busAddr == OFF_PRI_LOCK
		|=> busRdData == 8'($past(primarySectorLocked)))
		else $error("primary lock read mismatch");
	AST_SEC_LOCK: assert property (@(posedge clk) disable iff (rst)
		registerWindowSelect && busRdStrobe && busAddr == OFF_SEC_LOCK
		|=> busRdData == $past(securityAndSecondaryLocked))
		else $error("secondary lock read mismatch");
	AST_MAP_WRITE: assert property (@(posedge clk) disable iff (rst)
		hit(OFF_SPACE_MAP) ##1 !hit(OFF_SPACE_MAP)
		|-> memorySpaceMap == $past(busWrData))
		else $error("space map not held");
	AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (rst)
		registerWindowSelect && busRdStrobe && busAddr == 8'hff |=> busRdData == 8'h00)
		else $error("unmapped offset read nonzero");

	// read data stands until the next read; writes need the window select
	AST_RD_HOLD: assert property (@(posedge clk) disable iff (rst)
		!(registerWindowSelect && busRdStrobe) |=> $stable(busRdData))
		else $error("read data changed without read");
	AST_NOSEL_WRITE: assert property (@(posedge clk) disable iff (rst)
		!registerWindowSelect |=> $stable(addressPage) && $stable(memorySpaceMap))
		else $error("register written without window select");
endmodule

// ---- iorsm_pkg.sv ----
// iorsm_pkg: offsets, reset values and layout of the internal register window.
// assumes an 8-bit microcontroller bus with byte-wide register accesses.
package iorsm_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] OFF_A_IN = 8'h00;
	localparam logic [7:0] OFF_B_IN = 8'h01;
	localparam logic [7:0] OFF_A_CTL = 8'h02;
	localparam logic [7:0] OFF_B_CTL = 8'h03;
	localparam logic [7:0] OFF_A_OUT = 8'h04;
	localparam logic [7:0] OFF_B_OUT = 8'h05;
	localparam logic [7:0] OFF_A_DIR = 8'h06;
	localparam logic [7:0] OFF_B_DIR = 8'h07;
	localparam logic [7:0] OFF_A_DRV = 8'h08;
	localparam logic [7:0] OFF_B_DRV = 8'h09;
	localparam logic [7:0] OFF_A_IMC = 8'h0a;
	localparam logic [7:0] OFF_B_IMC = 8'h0b;
	localparam logic [7:0] OFF_A_OEN = 8'h0c;
	localparam logic [7:0] OFF_B_OEN = 8'h0d;
	localparam logic [7:0] OFF_C_IN = 8'h10;
	localparam logic [7:0] OFF_D_IN = 8'h11;
	localparam logic [7:0] OFF_C_OUT = 8'h12;
	localparam logic [7:0] OFF_D_OUT = 8'h13;
	localparam logic [7:0] OFF_C_DIR = 8'h14;
	localparam logic [7:0] OFF_D_DIR = 8'h15;
	localparam logic [7:0] OFF_C_DRV = 8'h16;
	localparam logic [7:0] OFF_D_DRV = 8'h17;
	localparam logic [7:0] OFF_C_IMC = 8'h18;
	localparam logic [7:0] OFF_C_OEN = 8'h1a;
	localparam logic [7:0] OFF_D_OEN = 8'h1b;
	localparam logic [7:0] OFF_OMC_AB = 8'h20;
	localparam logic [7:0] OFF_OMC_BC = 8'h21;
	localparam logic [7:0] OFF_MSK_AB = 8'h22;
	localparam logic [7:0] OFF_MSK_BC = 8'h23;
	localparam logic [7:0] OFF_PWR0 = 8'hb0;
	localparam logic [7:0] OFF_PWR2 = 8'hb4;
	localparam logic [7:0] OFF_PRI_LOCK = 8'hc0;
	localparam logic [7:0] OFF_SEC_LOCK = 8'hc2;
	localparam logic [7:0] OFF_TEST_EN = 8'hc7;
	localparam logic [7:0] OFF_PAGE = 8'he0;
	localparam logic [7:0] OFF_SPACE_MAP = 8'he2;
	localparam logic [7:0] RST_REG = 8'h00;
	localparam int PRI_SECTORS = 8;
	localparam int SEC_SECTORS = 4;
	localparam int PRI_SECTOR_BYTES = 32768;
	localparam int SEC_SECTOR_BYTES = 16384;
	// bus types choosing the latched address layout on ports a and b
	typedef enum logic [0:0] {
		IORSM_BUS_MUX = 1'b0,
		IORSM_BUS_NONMUX = 1'b1
	} iorsm_bus_t;
endpackage

// ---- iorsm_mcu_model.sv ----
// iorsm_mcu_model: microcontroller side of the register window bus.
// assumes clk from the bench; each task call makes one whole access.
`timescale 1ns/1ps
module iorsm_mcu_model (
	input wire logic clk,
	output logic registerWindowSelect,
	output logic [7:0] busAddr,
	output logic [7:0] busWrData,
	output logic busWrStrobe,
	output logic busRdStrobe,
	input wire logic [7:0] busRdData
);
	initial begin
		registerWindowSelect = 1'b0;
		busAddr = 8'h00;
		busWrData = 8'h00;
		busWrStrobe = 1'b0;
		busRdStrobe = 1'b0;
	end
	// s low gives a write that misses the window
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic s);
		@(posedge clk);
		#1;
		registerWindowSelect = s;
		busAddr = a;
		busWrData = d;
		busWrStrobe = 1'b1;
		@(posedge clk);
		#1;
		registerWindowSelect = 1'b0;
		busWrStrobe = 1'b0;
		// released lines show the inverse of the last value
		busAddr = ~a;
		busWrData = ~d;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		registerWindowSelect = 1'b1;
		busAddr = a;
		busRdStrobe = 1'b1;
		@(posedge clk);
		#1;
		d = busRdData;
		registerWindowSelect = 1'b0;
		busRdStrobe = 1'b0;
		busAddr = ~a;
	endtask
endmodule

// ---- io_register_space_map_tb_top.sv ----
// io_register_space_map_tb_top: random and corner tests of the register window.
// assumes iorsm_regs with default port widths and the bus model beside it.
`timescale 1ns/1ps
module io_register_space_map_tb_top;
	import iorsm_pkg::*;
	logic clk, rst, registerWindowSelect, busWrStrobe, busRdStrobe, decodeSramSel, sramSelect;
	logic [7:0] busAddr, busWrData, busRdData, latchedAddr, firstCellOutputs, secondCellOutputs;
	logic [7:0] portAPinIn, portBPinIn, portCPinIn, portDPinIn, portAPinOut, portBPinOut;
	logic [7:0] portCPinOut, portDPinOut, portAPinOe, portBPinOe, portCPinOe, portDPinOe;
	logic [7:0] portADriveType, portBDriveType, portCDriveType, portDDriveType;
	logic [7:0] portAInputCells, portBInputCells, portCInputCells, firstCellLoadData;
	logic [7:0] firstCellLoadEnable, secondCellLoadData, secondCellLoadEnable;
	logic [7:0] primarySectorLocked, securityAndSecondaryLocked, powerControl0, powerControl2;
	logic [7:0] testPortEnable, addressPage, memorySpaceMap, decodePrimarySel;
	logic [7:0] primarySectorSelects, d, v;
	logic [3:0] decodeSecondarySel, secondarySectorSelects;
	iorsm_bus_t busType;
	logic [7:0] shadow [256];
	logic [7:0] rwList [21] = '{OFF_A_CTL, OFF_B_CTL, OFF_A_OUT, OFF_B_OUT, OFF_A_DIR, OFF_B_DIR,
		OFF_A_DRV, OFF_B_DRV, OFF_C_OUT, OFF_D_OUT, OFF_C_DIR, OFF_D_DIR, OFF_C_DRV, OFF_D_DRV,
		OFF_MSK_AB, OFF_MSK_BC, OFF_PWR0, OFF_PWR2, OFF_TEST_EN, OFF_PAGE, OFF_SPACE_MAP};
	logic [7:0] roList [18] = '{OFF_A_IN, OFF_B_IN, OFF_C_IN, OFF_D_IN, OFF_A_IMC, OFF_B_IMC,
		OFF_C_IMC, OFF_OMC_AB, OFF_OMC_BC, OFF_PRI_LOCK, OFF_SEC_LOCK, 8'h0e, 8'h19, 8'h1c,
		8'h30, 8'hb2, 8'hc1, 8'hff};
	int fails, checkCount, cycles, seedVal;
	iorsm_regs dut (.*);
	iorsm_mcu_model mcu (.*);
	always #4 clk = ~clk;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic rand_inputs;
		{portAPinIn, portBPinIn, portCPinIn, portDPinIn} = $urandom;
		{portAInputCells, portBInputCells, portCInputCells, latchedAddr} = $urandom;
		{firstCellOutputs, secondCellOutputs, primarySectorLocked} = 24'($urandom);
		{securityAndSecondaryLocked, decodePrimarySel, decodeSecondarySel} = 20'($urandom);
		decodeSramSel = 1'($urandom);
	endtask
	function automatic logic [7:0] exp_ro(input logic [7:0] a);
		case (a)
			OFF_A_IN: return portAPinIn;
			OFF_B_IN: return portBPinIn;
			OFF_C_IN: return portCPinIn;
			OFF_D_IN: return portDPinIn;
			OFF_A_IMC: return portAInputCells;
			OFF_B_IMC: return portBInputCells;
			OFF_C_IMC: return portCInputCells;
			OFF_OMC_AB: return firstCellOutputs;
			OFF_OMC_BC: return secondCellOutputs;
			OFF_PRI_LOCK: return primarySectorLocked;
			OFF_SEC_LOCK: return securityAndSecondaryLocked;
			default: return 8'h00;
		endcase
	endfunction
	// per pin: control bit set takes t, clear takes f
	function automatic logic [7:0] mix(input logic [7:0] c, input logic [7:0] t,
		input logic [7:0] f);
		return (c & t) | (~c & f);
	endfunction
	// cell group loads are seen in the cycle of the write strobe
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			give_verdict;
		end
		if (!rst && registerWindowSelect && busWrStrobe && busAddr == OFF_OMC_AB) begin
			check(firstCellLoadData, busWrData);
			check(firstCellLoadEnable, ~shadow[OFF_MSK_AB]);
		end
		if (!rst && registerWindowSelect && busWrStrobe && busAddr == OFF_OMC_BC) begin
			check(secondCellLoadData, busWrData);
			check(secondCellLoadEnable, ~shadow[OFF_MSK_BC]);
		end
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		busType = IORSM_BUS_MUX;
		seedVal = $urandom(32'h9a4386e3);
		foreach (shadow[i]) shadow[i] = RST_REG;
		rand_inputs();
		repeat (4) @(posedge clk);
		#1;
		rst = 1'b0;
		foreach (rwList[i]) begin
			mcu.rd_reg(rwList[i], d);
			check(d, RST_REG);
		end
		repeat (3) begin
			foreach (rwList[i]) begin
				v = 8'($urandom);
				mcu.wr_reg(rwList[i], v, 1'b1);
				shadow[rwList[i]] = v;
			end
			foreach (rwList[i]) begin
				mcu.rd_reg(rwList[i], d);
				check(d, shadow[rwList[i]]);
			end
			check(portCPinOut, shadow[OFF_C_OUT]);
			check(portDPinOut, shadow[OFF_D_OUT]);
			check(portAPinOut, mix(shadow[OFF_A_CTL], latchedAddr, shadow[OFF_A_OUT]));
			check(portBPinOut, mix(shadow[OFF_B_CTL], latchedAddr, shadow[OFF_B_OUT]));
			check(portAPinOe, mix(shadow[OFF_A_CTL], 8'hff, shadow[OFF_A_DIR]));
			check(portBPinOe, mix(shadow[OFF_B_CTL], 8'hff, shadow[OFF_B_DIR]));
			check(portCPinOe, shadow[OFF_C_DIR]);
			check(portDPinOe, shadow[OFF_D_DIR]);
			check(portADriveType, shadow[OFF_A_DRV]);
			check(portBDriveType, shadow[OFF_B_DRV]);
			check(portCDriveType, shadow[OFF_C_DRV]);
			check(portDDriveType, shadow[OFF_D_DRV]);
			check(memorySpaceMap, shadow[OFF_SPACE_MAP]);
			check(powerControl0, shadow[OFF_PWR0]);
			check(powerControl2, shadow[OFF_PWR2]);
			check(testPortEnable, shadow[OFF_TEST_EN]);
			check(addressPage, shadow[OFF_PAGE]);
			mcu.rd_reg(OFF_A_OEN, d);
			check(d, mix(shadow[OFF_A_CTL], 8'hff, shadow[OFF_A_DIR]));
			mcu.rd_reg(OFF_C_OEN, d);
			check(d, shadow[OFF_C_DIR]);
			mcu.rd_reg(OFF_D_OEN, d);
			check(d, shadow[OFF_D_DIR]);
			repeat (2) mcu.wr_reg(OFF_OMC_AB + 8'($urandom % 2), 8'($urandom), 1'b1);
		end
		mcu.wr_reg(OFF_PAGE, ~shadow[OFF_PAGE], 1'b0);
		check(addressPage, shadow[OFF_PAGE]);
		repeat (4) begin
			foreach (roList[i]) mcu.wr_reg(roList[i], 8'($urandom), 1'b1);
			rand_inputs();
			foreach (roList[i]) begin
				mcu.rd_reg(roList[i], d);
				check(d, exp_ro(roList[i]));
			end
			mcu.rd_reg(OFF_PRI_LOCK, d);
			check(d, primarySectorLocked);
			mcu.rd_reg(OFF_SEC_LOCK, d);
			check(d, securityAndSecondaryLocked);
			#1;
			check(primarySectorSelects, decodePrimarySel);
			check({3'h0, sramSelect, secondarySectorSelects}, {3'h0, decodeSramSel, decodeSecondarySel});
		end
		// writes to read-only and unassigned offsets left the registers alone
		foreach (rwList[i]) begin
			mcu.rd_reg(rwList[i], d);
			check(d, shadow[rwList[i]]);
		end
		mcu.wr_reg(OFF_A_CTL, 8'hff, 1'b1);
		mcu.wr_reg(OFF_B_CTL, 8'hff, 1'b1);
		for (int b = 0; b < 2; b++) begin
			@(posedge clk);
			#1;
			busType = iorsm_bus_t'(b);
			rand_inputs();
			#1;
			check(portBPinOut, latchedAddr);
			check(b ? portAPinOe : portAPinOut, b ? 8'h00 : latchedAddr);
		end
		repeat (2) @(posedge clk);
		give_verdict;
	end
endmodule
